// ---- rtl/dep_pkg.sv ----
// constants for the dual-edge pixel input capture
package dep_pkg;
  // bus and field widths
  localparam int BUS_W     = 36;
  localparam int COMP_W    = 12;
  localparam int PIX_W     = 3 * COMP_W + 3;
  localparam int FIFO_DEPTH = 32;
  // data bus width modes
  typedef enum logic [1:0] {
    DEP_W18,
    DEP_W15,
    DEP_W12,
    DEP_FULL
  } dep_mode_t;
  // 18-bit lane positions
  localparam int W18_LO    = 0;
  localparam int W18_G_LO  = 12;
  localparam int W18_R_LO  = 6;
  // 15-bit lane positions
  localparam int W15_B_LO  = 2;
  localparam int W15_G_LO  = 14;
  localparam int W15_R_LO  = 7;
  // 12-bit lane positions
  localparam int W12_B_LO  = 4;
  localparam int W12_G_LO  = 16;
  localparam int W12_R_LO  = 8;
  // full-width lane positions (half-rate clock variant)
  localparam int FULL_B_LO = 0;
  localparam int FULL_G_LO = 12;
  localparam int FULL_R_LO = 24;
  // link limits
  localparam real LINK_MAX_MHZ = 148.5;
  localparam real SYS_MHZ      = 20.0;
endpackage : dep_pkg

// ---- rtl/dep_fifo.sv ----
// small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dep_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push;
  wire              pop;

  // honest full and empty from the occupancy count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  // storage written by index, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q] <= in_data;
  end

  // pointers and count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dep_fifo

// ---- rtl/dep_capture.sv ----
// dual-edge pixel capture: samples link pins, pairs half-words into pixels
`timescale 1ns/1ps
module dep_capture (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // mode straps
  input  wire dep_pkg::dep_mode_t         bus_mode,
  // link pins
  input  wire logic                       pixel_clk,
  input  wire logic [dep_pkg::BUS_W-1:0]  pixel_data_bus,
  input  wire logic                       hsync_line,
  input  wire logic                       vsync_line,
  input  wire logic                       data_enable_line,
  // pixel output stream
  output logic                            pix_valid,
  input  wire logic                       pix_ready,
  output logic [dep_pkg::COMP_W-1:0]      pix_blue,
  output logic [dep_pkg::COMP_W-1:0]      pix_green,
  output logic [dep_pkg::COMP_W-1:0]      pix_red,
  output logic                            pix_hsync,
  output logic                            pix_vsync,
  output logic                            pix_de,
  // status
  output logic                            overflow
);
  localparam int BW = dep_pkg::BUS_W;
  localparam int CW = dep_pkg::COMP_W;
  localparam int PW = dep_pkg::PIX_W;

  // two-stage synchronisers for every link pin
  logic          clk_s1_q, clk_s2_q, clk_s3_q;
  logic [BW-1:0] dat_s1_q, dat_s2_q;
  logic [2:0]    ctl_s1_q, ctl_s2_q;

  // the link is sampled at the system rate, so in this model the
  // usable link rate is bounded well below the documented ceiling
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dat_s1_q <= '0;
      dat_s2_q <= '0;
      ctl_s1_q <= '0;
      ctl_s2_q <= '0;
    end else begin
      clk_s1_q <= pixel_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= pixel_data_bus;
      dat_s2_q <= dat_s1_q;
      ctl_s1_q <= {hsync_line, vsync_line, data_enable_line};
      ctl_s2_q <= ctl_s1_q;
    end
  end

  // edge detection on the synchronised link clock
  wire rise_e = clk_s2_q & ~clk_s3_q;
  wire fall_e = ~clk_s2_q & clk_s3_q;

  // first half-word, held from the rising edge
  logic [BW-1:0] first_q;
  logic          have_first_q;
  logic          overflow_q;

  // assemble one pixel from both half-words
  function automatic logic [3*CW-1:0] dep_assemble(
    input dep_pkg::dep_mode_t m,
    input logic [BW-1:0]      a,
    input logic [BW-1:0]      b);
    logic [CW-1:0] bl, gr, rd;
    bl = '0;
    gr = '0;
    rd = '0;
    case (m)
      dep_pkg::DEP_W18: begin
        bl = a[dep_pkg::W18_LO +: 12];
        gr = {b[dep_pkg::W18_LO +: 6], a[dep_pkg::W18_G_LO +: 6]};
        rd = b[dep_pkg::W18_R_LO +: 12];
      end
      dep_pkg::DEP_W15: begin
        bl = {2'h0, a[dep_pkg::W15_B_LO +: 10]};
        gr = {2'h0, b[dep_pkg::W15_B_LO +: 5],
              a[dep_pkg::W15_G_LO +: 5]};
        rd = {2'h0, b[dep_pkg::W15_G_LO +: 5],
              b[dep_pkg::W15_R_LO +: 5]};
      end
      dep_pkg::DEP_W12: begin
        bl = {4'h0, a[dep_pkg::W12_B_LO +: 8]};
        gr = {4'h0, b[dep_pkg::W12_B_LO +: 4],
              a[dep_pkg::W12_G_LO +: 4]};
        rd = {4'h0, b[dep_pkg::W12_G_LO +: 4],
              b[dep_pkg::W12_R_LO +: 4]};
      end
      dep_pkg::DEP_FULL: begin
        // full-width word latched on the falling edge is a whole pixel on its own
        bl = b[dep_pkg::FULL_B_LO +: 12];
        gr = b[dep_pkg::FULL_G_LO +: 12];
        rd = b[dep_pkg::FULL_R_LO +: 12];
      end
      default: begin
        bl = '0;
      end
    endcase
    return {rd, gr, bl};
  endfunction : dep_assemble

  // pixel word toward the fifo; syncs from own lines at the falling edge
  wire [3*CW-1:0] comp_w = dep_assemble(bus_mode, first_q, dat_s2_q);
  wire [PW-1:0]   word_w = {ctl_s2_q, comp_w};
  wire            full_m = (bus_mode == dep_pkg::DEP_FULL);
  // full mode: each edge of the half-rate clock latches a whole pixel
  wire            push_w = full_m ? (rise_e | fall_e)
                                  : (fall_e & have_first_q);
  wire [PW-1:0]   push_d = (full_m && rise_e)
                         ? {ctl_s2_q,
                            dat_s2_q[dep_pkg::FULL_R_LO +: 12],
                            dat_s2_q[dep_pkg::FULL_G_LO +: 12],
                            dat_s2_q[dep_pkg::FULL_B_LO +: 12]}
                         : word_w;
  wire            fifo_rdy;

  // rising edge opens a pixel, falling edge closes it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      first_q      <= '0;
      have_first_q <= 1'b0;
      overflow_q   <= 1'b0;
    end else begin
      if (rise_e) begin
        first_q      <= dat_s2_q;
        have_first_q <= 1'b1;
      end else if (fall_e) begin
        have_first_q <= 1'b0;
      end
      // link cannot stall, so a full fifo drops and is flagged
      if (push_w && !fifo_rdy) overflow_q <= 1'b1;
    end
  end

  assign overflow = overflow_q;

  // buffer between link rate and consumer
  logic [PW-1:0] out_w;
  dep_fifo #(
    .WIDTH (PW),
    .DEPTH (dep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (push_w),
    .in_ready  (fifo_rdy),
    .in_data   (push_d),
    .out_valid (pix_valid),
    .out_ready (pix_ready),
    .out_data  (out_w)
  );

  assign {pix_hsync, pix_vsync, pix_de} = out_w[PW-1 -: 3];
  assign pix_red   = out_w[2*CW +: CW];
  assign pix_green = out_w[CW +: CW];
  assign pix_blue  = out_w[0 +: CW];

  // one pixel per link period in halved modes
  pair_on_fall_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (fall_e && have_first_q && !full_m) |-> push_w)
    else $error("completed pixel not pushed");
  first_on_rise_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    rise_e |=> (have_first_q && first_q == $past(dat_s2_q)))
    else $error("rising half-word not held");
  no_lone_half_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (!full_m && !have_first_q) |-> !push_w)
    else $error("push without first half");
  // lane checks written from the bit positions, not from the function
  blue18_pos_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (push_w && bus_mode == dep_pkg::DEP_W18)
      |-> push_d[11:0] == first_q[11:0])
    else $error("18-bit blue misplaced");
  red18_pos_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (push_w && bus_mode == dep_pkg::DEP_W18)
      |-> push_d[35:24] == dat_s2_q[17:6])
    else $error("18-bit red misplaced");
  blue15_pos_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (push_w && bus_mode == dep_pkg::DEP_W15)
      |-> push_d[11:0] == {2'h0, first_q[11:2]})
    else $error("15-bit blue misplaced");
  red15_pos_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (push_w && bus_mode == dep_pkg::DEP_W15)
      |-> push_d[33:24] == {dat_s2_q[18:14], dat_s2_q[11:7]})
    else $error("15-bit red misplaced");
  green12_pos_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (push_w && bus_mode == dep_pkg::DEP_W12)
      |-> push_d[19:12] == {dat_s2_q[7:4], first_q[19:16]})
    else $error("12-bit green misplaced");
  red12_pos_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (push_w && bus_mode == dep_pkg::DEP_W12)
      |-> push_d[35:24] == {4'h0, dat_s2_q[19:16], dat_s2_q[11:8]})
    else $error("12-bit red misplaced");
  sync_lines_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    push_w |-> push_d[PW-1 -: 3] == ctl_s2_q)
    else $error("sync lines not carried");
  full_both_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (full_m && (rise_e || fall_e)) |-> push_w)
    else $error("half-rate edge missed");
  full_map_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (push_w && full_m) |-> push_d[35:0] == dat_s2_q)
    else $error("full-width lanes misplaced");
endmodule : dep_capture

// ---- tb/dep_src.sv ----
// front-end source model driving the dual-edge pixel bus
`timescale 1ns/1ps
module dep_src (
  // clock
  input  wire logic clk_sys,
  // link pins
  output logic        pixel_clk,
  output logic [35:0] pixel_data_bus,
  output logic        hsync_line,
  output logic        vsync_line,
  output logic        data_enable_line
);
  // link clock stands low between pixels
  initial begin
    pixel_clk = 1'b0;
    pixel_data_bus = 36'h0;
    {hsync_line, vsync_line, data_enable_line} = 3'h0;
  end
  // one edge; data settles two cycles early as the capture has no deskew
  task automatic edge_out(input logic l, input logic [35:0] d,
                          input logic [2:0] s);
    pixel_data_bus <= d;
    {hsync_line, vsync_line, data_enable_line} <= s;
    repeat (2) @(posedge clk_sys);
    pixel_clk <= l;
    repeat (2) @(posedge clk_sys);
  endtask : edge_out
  // lanes of both halves, second half on top; unused lines ground
  function automatic logic [71:0] lanes(input dep_pkg::dep_mode_t m,
                                        input logic [11:0] b, g, r);
    case (m)
      dep_pkg::DEP_W15: return {17'h0, r[9:5], 2'h0, r[4:0], g[9:5], 2'h0,
                                17'h0, g[4:0], 2'h0, b[9:0], 2'h0};
      dep_pkg::DEP_W12: return {16'h0, r[7:4], 4'h0, r[3:0], g[7:4], 4'h0,
                                16'h0, g[3:0], 4'h0, b[7:0], 4'h0};
      default: return {18'h0, r, g[11:6], 18'h0, g[5:0], b};
    endcase
  endfunction : lanes
  // one pixel per link period, first half on the rising edge
  task automatic send_half(input dep_pkg::dep_mode_t m,
                           input logic [11:0] b, g, r,
                           input logic [2:0] s0, s1);
    logic [71:0] v;
    v = lanes(m, b, g, r);
    edge_out(1'b1, v[35:0], s0);
    edge_out(1'b0, v[71:36], s1);
  endtask : send_half
endmodule : dep_src

// ---- tb/dual_edge_pixel_input_tb.sv ----
// self-checking bench for the dual-edge pixel capture
`timescale 1ns/1ps
module dual_edge_pixel_input_tb;
  logic clk_sys, rst_b, pix_ready, stall, pixel_clk;
  logic hsync_line, vsync_line, data_enable_line, pix_valid;
  logic pix_hsync, pix_vsync, pix_de, overflow;
  logic [35:0] pixel_data_bus;
  logic [11:0] pix_blue, pix_green, pix_red;
  logic [38:0] exp_q[$];
  logic [15:0] lfsr_q;
  int          error_cnt, n_checks;
  dep_pkg::dep_mode_t bus_mode;
  dep_src u_dep_src (.clk_sys, .pixel_clk, .pixel_data_bus, .hsync_line,
                     .vsync_line, .data_enable_line);
  dep_capture u_dep_capture (.clk_sys, .rst_b, .bus_mode, .pixel_clk,
    .pixel_data_bus, .hsync_line, .vsync_line, .data_enable_line,
    .pix_valid, .pix_ready, .pix_blue, .pix_green, .pix_red, .pix_hsync,
    .pix_vsync, .pix_de, .overflow);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // fixed-seed lfsr keeps runs repeatable
  function automatic logic [11:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[11:0];
  endfunction : rnd
  task automatic cmp(input logic [38:0] got, input logic [38:0] e);
    n_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, e);
    end
  endtask : cmp
  task automatic check_pix(input logic [38:0] got);
    cmp(got, (exp_q.size() > 0) ? exp_q.pop_front() : ~got);
  endtask : check_pix
  task automatic check_flag(input logic got, input logic e);
    cmp({38'h0, got}, {38'h0, e});
  endtask : check_flag
  // model of the fifo: a stalled consumer lets only 32 pixels in
  task automatic push(input logic [38:0] v);
    if (!stall || exp_q.size() < dep_pkg::FIFO_DEPTH) exp_q.push_back(v);
  endtask : push
  // random consumer; ready sampled with the data at the same edge
  // a fresh draw every cycle, so ready can never stick low in a drain
  always @(posedge clk_sys) pix_ready <= ~stall & (rnd() > 12'h3ff);
  always @(posedge clk_sys) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      check_pix({pix_blue, pix_green, pix_red, pix_hsync, pix_vsync,
                 pix_de});
    end
  end
  // one pixel, two in full mode; syncs drawn per edge to show the completing edge wins
  task automatic send(input dep_pkg::dep_mode_t m);
    logic [11:0] b, g, r, mk;
    logic [2:0]  s0, s1;
    b = rnd();
    g = rnd();
    r = rnd();
    s0 = 3'(rnd());
    s1 = 3'(rnd());
    mk = (m == dep_pkg::DEP_W15) ? 12'h3ff :
         (m == dep_pkg::DEP_W12) ? 12'h0ff : 12'hfff;
    if (m == dep_pkg::DEP_FULL) begin
      push({b, g, r, s0});
      u_dep_src.edge_out(1'b1, {r, g, b}, s0);
      push({r, b, g, s1});
      u_dep_src.edge_out(1'b0, {g, b, r}, s1);
    end else begin
      push({b & mk, g & mk, r & mk, s1});
      u_dep_src.send_half(m, b, g, r, s0, s1);
    end
  endtask : send
  // bounded wait for the model queue to empty, then nothing extra
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      final_report();
    end
    repeat (4) @(posedge clk_sys);
    check_flag(pix_valid, 1'b0);
  endtask : drain
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  initial begin
    rst_b = 1'b0;
    stall = 1'b0;
    pix_ready = 1'b0;
    bus_mode = dep_pkg::DEP_W18;
    lfsr_q = 16'h0bb3;
    error_cnt = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_sys);
    check_flag(pix_valid, 1'b0);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // every width mode, then the half-rate full bus
    for (int t = 0; t < 4; t++) begin
      bus_mode <= dep_pkg::dep_mode_t'(t);
      @(posedge clk_sys);
      repeat (10) send(dep_pkg::dep_mode_t'(t));
      drain();
      $display("test %0d done", t);
    end
    check_flag(overflow, 1'b0);
    // stalled consumer: 34 pixels, the 33rd and 34th find the fifo full and are lost
    stall <= 1'b1;
    @(posedge clk_sys);
    repeat (17) send(dep_pkg::DEP_FULL);
    repeat (8) @(posedge clk_sys);
    check_flag(overflow, 1'b1);
    stall <= 1'b0;
    drain();
    $display("test 4 done");
    final_report();
  end
endmodule : dual_edge_pixel_input_tb
